// [hw/nsoc_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - Four independent stages; only stages 3 and 4 may select inverse time.
// - Each stage has its own enable; a disabled stage never picks up or trips.
// - Negative sequence is one third of A plus a-squared B plus a C.
// - Each stage drives its own pickup and trip outputs.
// - Thresholds are per unit, scaled by rated primary current before compare.
// - Definite time picks up above threshold, resets below 96 percent.
// - Definite time trips after its set delay; zero delay trips at once.
// - Zero dropout delay resets the stage at once below reset level.
// - Nonzero dropout delay holds pickup for that delay before reset.
// - A tripped stage resets at once when pickup clears.
// - Stage 3 and 4 thresholds clamp to 0.005..20.0, default 2.0.
// - Stage 3 and 4 trip delays clamp to 0..300000 ms, default 400.
// - Stage 3 and 4 dropout delays clamp to 0..60000 ms, default 0.
// - Stages 3 and 4 have a constant time adder, 0..30000 ms, default 0.
// - Stages 3 and 4 have a maximum operate time, default 5800 ms.
// - Stages 3 and 4 have a minimum operate time, default 1200 ms.
// - Stages 3 and 4 have a minimum start current, 1.0..4.0, default 1.0.
// - Stages 3 and 4 have a cold load multiplier limit, 1.0..20.0.
// - Stage 4 harmonic blocking enable resets to off.
// - Every stage resets non-directional; direction is selectable per stage.
// - Inverse time picks up above 1.04 times threshold, resets below it.
// - Stage and general block inputs; each stage reports its blocked state.
module nsoc_top #(
  parameter int TICK_CYCLES = nsoc_pkg::NSOC_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic signed [15:0] ia_re_in,
  input wire logic signed [15:0] ia_im_in,
  input wire logic signed [15:0] ib_re_in,
  input wire logic signed [15:0] ib_im_in,
  input wire logic signed [15:0] ic_re_in,
  input wire logic signed [15:0] ic_im_in,
  input wire logic sample_valid_in,
  input wire logic [3:0] stage_block_input_in,
  input wire logic general_block_in,
  output logic [3:0] pickup_out,
  output logic [3:0] trip_out,
  output logic [3:0] stage_blocked_flag_out
);
  import nsoc_pkg::*;

  typedef struct packed {
    logic [3:0] stage_enable;
    logic [3:0] stage_harmonic_block_enable;
    logic [1:0] inverse;
    logic [3:0][1:0] stage_direction_select;
    logic [15:0] rated;
    logic [3:0][15:0] thr;
    logic [3:0][18:0] stage_trip_delay;
    logic [3:0][15:0] stage_dropout_delay;
    logic [1:0][15:0] stage_constant_time_adder;
    logic [1:0][15:0] stage_max_operate_time;
    logic [1:0][15:0] stage_min_operate_time;
    logic [1:0][15:0] stage_min_start_current;
    logic [1:0][15:0] stage_cold_load_mult_limit;
    logic [31:0] rdata;
    logic [15:0] tick_cnt;
    logic tick;
    logic [4:0] blk_s1;
    logic [4:0] blk_s2;
    logic [3:0] blocked;
  } nsoc_top_st_t;

  nsoc_top_st_t st_reg, st_next;

  logic [33:0] mag_sq;
  logic [3:0] inv_all;
  logic [3:0][31:0] level;
  logic [3:0][18:0] trip_eff;
  logic [2:0] bank;
  logic [2:0] fld;
  logic [1:0] stg;
  logic is_stage;
  logic ext;
  logic hit;
  logic setup;
  logic wr;
  logic [31:0] rd;

  // Sequence filter in front of all four stages
  nsoc_negseq u_negseq (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ia_re_in(ia_re_in),
    .ia_im_in(ia_im_in),
    .ib_re_in(ib_re_in),
    .ib_im_in(ib_im_in),
    .ic_re_in(ic_re_in),
    .ic_im_in(ic_im_in),
    .valid_in(sample_valid_in),
    .mag_sq_out(mag_sq)
  );

  // Stages 1 and 2 are hard-wired to definite time
  assign inv_all = {st_reg.inverse, 2'b00};

  // Per-unit threshold times rated current, in thousandths of a sample LSB
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level[i] = 32'(st_reg.thr[i]) * 32'(st_reg.rated);
    end
  end

  // Inverse curve not integrated: trip at min time plus adder, capped at max time
  always_comb begin
    logic [18:0] sum;
    sum = '0;
    for (int i = 0; i < 4; i++) begin
      trip_eff[i] = st_reg.stage_trip_delay[i];
    end
    for (int j = 0; j < 2; j++) begin
      sum = 19'(st_reg.stage_min_operate_time[j])
          + 19'(st_reg.stage_constant_time_adder[j]);
      if (sum > 19'(st_reg.stage_max_operate_time[j])) begin
        sum = 19'(st_reg.stage_max_operate_time[j]);
      end
      if (st_reg.inverse[j]) begin
        trip_eff[j + 2] = sum;
      end
    end
  end

  // The four protection stages
  for (genvar gi = 0; gi < 4; gi++) begin : g_stage
    nsoc_stage u_stage (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .enable_in(st_reg.stage_enable[gi]),
      .inverse_in(inv_all[gi]),
      .blocked_in(st_reg.blocked[gi]),
      .tick_in(st_reg.tick),
      .mag_sq_in(mag_sq),
      .level_in(level[gi]),
      .trip_delay_in(trip_eff[gi]),
      .drop_delay_in(st_reg.stage_dropout_delay[gi]),
      .pickup_out(pickup_out[gi]),
      .trip_out(trip_out[gi])
    );
  end

  // Address decode; stage banks sit at 0x20 steps, extras only for 3 and 4
  always_comb begin
    bank = paddr_in[7:5];
    fld = paddr_in[4:2];
    stg = 2'(bank - NSOC_BANK_FIRST);
    is_stage = (bank >= NSOC_BANK_FIRST) && (bank <= NSOC_BANK_LAST);
    ext = stg[1];
    hit = 1'b0;
    if (paddr_in == NSOC_CTRL_OFS || paddr_in == NSOC_DIR_OFS) begin
      hit = 1'b1;
    end else if (paddr_in == NSOC_RATED_OFS || paddr_in == NSOC_STATUS_OFS) begin
      hit = 1'b1;
    end else if (paddr_in == NSOC_MAG_OFS) begin
      hit = 1'b1;
    end else if (is_stage && paddr_in[1:0] == 2'b00) begin
      hit = (fld <= NSOC_F_DROP) || ext;
    end
    setup = psel_in && !penable_in;
    wr = psel_in && penable_in && pwrite_in && hit;
  end

  // Read mux; status and magnitude show the block's own state
  always_comb begin
    rd = 32'h0000_0000;
    if (paddr_in == NSOC_CTRL_OFS) begin
      rd[NSOC_EN_LSB +: 4] = st_reg.stage_enable;
      rd[NSOC_HARM_LSB +: 4] = st_reg.stage_harmonic_block_enable;
      rd[NSOC_INV_LSB +: 2] = st_reg.inverse;
    end else if (paddr_in == NSOC_DIR_OFS) begin
      rd[7:0] = st_reg.stage_direction_select;
    end else if (paddr_in == NSOC_RATED_OFS) begin
      rd[15:0] = st_reg.rated;
    end else if (paddr_in == NSOC_STATUS_OFS) begin
      rd[NSOC_PICK_LSB +: 4] = pickup_out;
      rd[NSOC_TRIP_LSB +: 4] = trip_out;
      rd[NSOC_BLK_LSB +: 4] = st_reg.blocked;
    end else if (paddr_in == NSOC_MAG_OFS) begin
      rd = mag_sq[33:2];
    end else if (hit) begin
      case (fld)
        NSOC_F_THR: rd[15:0] = st_reg.thr[stg];
        NSOC_F_TRIP: rd[18:0] = st_reg.stage_trip_delay[stg];
        NSOC_F_DROP: rd[15:0] = st_reg.stage_dropout_delay[stg];
        NSOC_F_ADDER: rd[15:0] = st_reg.stage_constant_time_adder[stg[0]];
        NSOC_F_MAXT: rd[15:0] = st_reg.stage_max_operate_time[stg[0]];
        NSOC_F_MINT: rd[15:0] = st_reg.stage_min_operate_time[stg[0]];
        NSOC_F_START: rd[15:0] = st_reg.stage_min_start_current[stg[0]];
        NSOC_F_COLD: rd[15:0] = st_reg.stage_cold_load_mult_limit[stg[0]];
        default: rd = 32'h0000_0000;
      endcase
    end
  end

  // Register writes, tick divider and block input synchronisers
  always_comb begin
    logic [31:0] wv;
    logic [15:0] thr_hi;
    logic [18:0] trip_hi;
    wv = pwdata_in;
    st_next = st_reg;
    thr_hi = ext ? NSOC_THR_MAX_IT : NSOC_THR_MAX_DT;
    trip_hi = ext ? NSOC_TRIP_MAX_IT : NSOC_TRIP_MAX_DT;
    // Read data is captured in setup so it is stable for the access phase
    if (setup) begin
      st_next.rdata = rd;
    end
    if (wr && paddr_in == NSOC_CTRL_OFS) begin
      st_next.stage_enable = wv[NSOC_EN_LSB +: 4];
      st_next.stage_harmonic_block_enable = wv[NSOC_HARM_LSB +: 4];
      st_next.inverse = wv[NSOC_INV_LSB +: 2];
    end
    if (wr && paddr_in == NSOC_DIR_OFS) begin
      st_next.stage_direction_select = wv[7:0];
    end
    if (wr && paddr_in == NSOC_RATED_OFS) begin
      st_next.rated = wv[15:0];
    end
    // Out-of-range settings are clamped rather than refused
    if (wr && is_stage) begin
      case (fld)
        NSOC_F_THR: begin
          st_next.thr[stg] = 16'(nsoc_clamp(wv, 32'(NSOC_THR_MIN), 32'(thr_hi)));
        end
        NSOC_F_TRIP: begin
          st_next.stage_trip_delay[stg] = 19'(nsoc_clamp(wv, 32'h0, 32'(trip_hi)));
        end
        NSOC_F_DROP: begin
          st_next.stage_dropout_delay[stg] =
            16'(nsoc_clamp(wv, 32'h0, 32'(NSOC_TIME_MAX)));
        end
        NSOC_F_ADDER: begin
          st_next.stage_constant_time_adder[stg[0]] =
            16'(nsoc_clamp(wv, 32'h0, 32'(NSOC_ADDER_MAX)));
        end
        NSOC_F_MAXT: begin
          st_next.stage_max_operate_time[stg[0]] =
            16'(nsoc_clamp(wv, 32'h0, 32'(NSOC_TIME_MAX)));
        end
        NSOC_F_MINT: begin
          st_next.stage_min_operate_time[stg[0]] =
            16'(nsoc_clamp(wv, 32'h0, 32'(NSOC_TIME_MAX)));
        end
        NSOC_F_START: begin
          st_next.stage_min_start_current[stg[0]] =
            16'(nsoc_clamp(wv, 32'(NSOC_MULT_ONE), 32'(NSOC_START_MAX)));
        end
        NSOC_F_COLD: begin
          st_next.stage_cold_load_mult_limit[stg[0]] =
            16'(nsoc_clamp(wv, 32'(NSOC_MULT_ONE), 32'(NSOC_COLD_MAX)));
        end
        default: begin
        end
      endcase
    end
    // Millisecond tick for every stage timer
    if (st_reg.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
      st_next.tick = 1'b0;
    end
    // Block pins are asynchronous: three flops before use
    st_next.blk_s1 = {general_block_in, stage_block_input_in};
    st_next.blk_s2 = st_reg.blk_s1;
    st_next.blocked = st_reg.blk_s2[3:0] | {4{st_reg.blk_s2[4]}};
  end

  // Register stage; reset loads the factory settings
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.rated <= NSOC_RATED_RST;
      st_reg.thr <= NSOC_THR_RST;
      st_reg.stage_trip_delay <= NSOC_TRIP_RST;
      st_reg.stage_max_operate_time <= {NSOC_MAXT_RST, NSOC_MAXT_RST};
      st_reg.stage_min_operate_time <= {NSOC_MINT_RST, NSOC_MINT_RST};
      st_reg.stage_min_start_current <= {NSOC_MULT_ONE, NSOC_MULT_ONE};
      st_reg.stage_cold_load_mult_limit <= {NSOC_MULT_ONE, NSOC_MULT_ONE};
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit;
  assign prdata_out = st_reg.rdata;
  assign stage_blocked_flag_out = st_reg.blocked;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  gen_block_a: assert property ($past(general_block_in, 3) |-> &stage_blocked_flag_out)
    else $error("general block not reported");
  block_quiet_a: assert property (&stage_blocked_flag_out |=> pickup_out == 4'h0)
    else $error("blocked stage picked up");
  tick_gap_a: assert property (st_reg.tick |=> !st_reg.tick [*2])
    else $error("tick spacing too short");
  enable_write_a: assert property (psel_in && penable_in && pwrite_in
    && paddr_in == NSOC_CTRL_OFS |=> st_reg.stage_enable == $past(pwdata_in[3:0]))
    else $error("enable write lost");
  apb_write_c: cover property (wr);
  apb_error_c: cover property (pslverr_out);
  all_trip_c: cover property (trip_out == 4'hF);
endmodule : nsoc_top

// [hw/nsoc_pkg.sv]
package nsoc_pkg;
  // Timebase
  localparam int NSOC_CLK_HZ = 50000000;
  localparam int NSOC_MS_PER_S = 1000;
  localparam int NSOC_TICK_MS = 1;
  localparam int NSOC_TICK_CYC = NSOC_CLK_HZ / NSOC_MS_PER_S * NSOC_TICK_MS;
  // Register byte offsets and stage bank decode
  localparam logic [7:0] NSOC_CTRL_OFS = 8'h00;
  localparam logic [7:0] NSOC_DIR_OFS = 8'h04;
  localparam logic [7:0] NSOC_RATED_OFS = 8'h08;
  localparam logic [7:0] NSOC_STATUS_OFS = 8'h0C;
  localparam logic [7:0] NSOC_MAG_OFS = 8'h10;
  localparam logic [2:0] NSOC_BANK_FIRST = 3'h1;
  localparam logic [2:0] NSOC_BANK_LAST = 3'h4;
  localparam logic [2:0] NSOC_F_THR = 3'h0;
  localparam logic [2:0] NSOC_F_TRIP = 3'h1;
  localparam logic [2:0] NSOC_F_DROP = 3'h2;
  localparam logic [2:0] NSOC_F_ADDER = 3'h3;
  localparam logic [2:0] NSOC_F_MAXT = 3'h4;
  localparam logic [2:0] NSOC_F_MINT = 3'h5;
  localparam logic [2:0] NSOC_F_START = 3'h6;
  localparam logic [2:0] NSOC_F_COLD = 3'h7;
  // Field positions
  localparam int NSOC_EN_LSB = 0;
  localparam int NSOC_HARM_LSB = 4;
  localparam int NSOC_INV_LSB = 8;
  localparam int NSOC_PICK_LSB = 0;
  localparam int NSOC_TRIP_LSB = 4;
  localparam int NSOC_BLK_LSB = 8;
  // Reset values and ranges; multiples in thousandths, times in ms
  localparam logic [15:0] NSOC_RATED_RST = 16'h03E8;
  localparam logic [3:0][15:0] NSOC_THR_RST = {16'h07D0, 16'h07D0, 16'h0FA0, 16'h0FA0};
  localparam logic [3:0][18:0] NSOC_TRIP_RST = {19'h00190, 19'h00190, 19'h00000, 19'h00000};
  localparam logic [15:0] NSOC_MAXT_RST = 16'h16A8;
  localparam logic [15:0] NSOC_MINT_RST = 16'h04B0;
  localparam logic [15:0] NSOC_MULT_ONE = 16'h03E8;
  localparam logic [15:0] NSOC_THR_MIN = 16'h0005;
  localparam logic [15:0] NSOC_THR_MAX_DT = 16'h9C40;
  localparam logic [15:0] NSOC_THR_MAX_IT = 16'h4E20;
  localparam logic [18:0] NSOC_TRIP_MAX_DT = 19'h0EA60;
  localparam logic [18:0] NSOC_TRIP_MAX_IT = 19'h493E0;
  localparam logic [15:0] NSOC_TIME_MAX = 16'hEA60;
  localparam logic [15:0] NSOC_ADDER_MAX = 16'h7530;
  localparam logic [15:0] NSOC_START_MAX = 16'h0FA0;
  localparam logic [15:0] NSOC_COLD_MAX = 16'h4E20;
  // Squared level ratios over 625, for 1.00, 0.96, 1.04
  localparam logic [9:0] NSOC_RATIO_DEN = 10'h271;
  localparam logic [9:0] NSOC_DT_PICK = 10'h271;
  localparam logic [9:0] NSOC_DT_DROP = 10'h240;
  localparam logic [9:0] NSOC_IT_PICK = 10'h2A4;
  localparam logic [9:0] NSOC_IT_DROP = 10'h271;
  localparam logic [19:0] NSOC_MAG_SCALE_SQ = 20'hF4240;
  // Sequence arithmetic constants
  localparam logic signed [35:0] NSOC_SQRT3_Q15 = 36'sh000006EDA;
  localparam logic signed [51:0] NSOC_THIRD_Q16 = 52'sh0000000005555;
  localparam int NSOC_Q15_SH = 15;
  localparam int NSOC_HALF_SH = 14;
  typedef enum logic [1:0] {NSOC_IDLE, NSOC_PICKED, NSOC_DROPPING, NSOC_TRIPPED} nsoc_stage_t;

  // Squared compare avoids a square root: 1e6*|I2|^2*625 > L^2*num
  function automatic logic nsoc_above(input logic [33:0] msq, input logic [31:0] lvl,
                                      input logic [9:0] num);
    logic [79:0] lhs;
    logic [79:0] rhs;
    lhs = 80'(msq) * 80'(NSOC_MAG_SCALE_SQ) * 80'(NSOC_RATIO_DEN);
    rhs = 80'(lvl) * 80'(lvl) * 80'(num);
    return lhs > rhs;
  endfunction : nsoc_above

  function automatic logic [31:0] nsoc_clamp(input logic [31:0] v, input logic [31:0] lo,
                                             input logic [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : nsoc_clamp
endpackage : nsoc_pkg

// [hw/nsoc_negseq.sv]
`timescale 1ns/1ps
module nsoc_negseq (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic signed [15:0] ia_re_in,
  input wire logic signed [15:0] ia_im_in,
  input wire logic signed [15:0] ib_re_in,
  input wire logic signed [15:0] ib_im_in,
  input wire logic signed [15:0] ic_re_in,
  input wire logic signed [15:0] ic_im_in,
  input wire logic valid_in,
  output logic [33:0] mag_sq_out
);
  import nsoc_pkg::*;
  typedef struct packed {
    logic signed [16:0] re;
    logic signed [16:0] im;
    logic vld;
    logic [33:0] msq;
  } nsoc_seq_st_t;
  nsoc_seq_st_t st_reg, st_next;

  // One component of (A + a^2 B + a C)/3; d carries the quadrature difference
  function automatic logic signed [16:0] seq_part(input logic signed [15:0] a,
      input logic signed [15:0] b, input logic signed [15:0] c, input logic signed [16:0] d);
    logic signed [35:0] acc;
    logic signed [51:0] prod;
    acc = (36'(a) <<< NSOC_Q15_SH) - (36'(b) <<< NSOC_HALF_SH) - (36'(c) <<< NSOC_HALF_SH)
          + 36'(d) * NSOC_SQRT3_Q15;
    prod = 52'(acc) * NSOC_THIRD_Q16;
    return prod[47:31];
  endfunction : seq_part

  // Two stages: components, then squared magnitude
  always_comb begin
    st_next = st_reg;
    st_next.vld = valid_in;
    if (valid_in) begin
      st_next.re = seq_part(ia_re_in, ib_re_in, ic_re_in, 17'(ib_im_in) - 17'(ic_im_in));
      st_next.im = seq_part(ia_im_in, ib_im_in, ic_im_in, 17'(ic_re_in) - 17'(ib_re_in));
    end
    if (st_reg.vld) begin
      st_next.msq = 34'(unsigned'(34'(st_reg.re) * 34'(st_reg.re)))
                  + 34'(unsigned'(34'(st_reg.im) * 34'(st_reg.im)));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mag_sq_out = st_reg.msq;
endmodule : nsoc_negseq

// [hw/nsoc_stage.sv]
`timescale 1ns/1ps
module nsoc_stage (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic inverse_in,
  input wire logic blocked_in,
  input wire logic tick_in,
  input wire logic [33:0] mag_sq_in,
  input wire logic [31:0] level_in,
  input wire logic [18:0] trip_delay_in,
  input wire logic [15:0] drop_delay_in,
  output logic pickup_out,
  output logic trip_out
);
  import nsoc_pkg::*;
  typedef struct packed {
    nsoc_pkg::nsoc_stage_t state;
    logic [18:0] tcnt;
    logic [15:0] dcnt;
    logic pick;
    logic trip;
  } nsoc_stg_st_t;
  nsoc_stg_st_t st_reg, st_next;
  logic above, below, live;

  // Pickup and reset levels per characteristic
  assign above = nsoc_above(mag_sq_in, level_in, inverse_in ? NSOC_IT_PICK : NSOC_DT_PICK);
  assign below = !nsoc_above(mag_sq_in, level_in, inverse_in ? NSOC_IT_DROP : NSOC_DT_DROP);
  assign live = enable_in && !blocked_in;

  always_comb begin
    st_next = st_reg;
    if (!live) begin
      st_next.state = NSOC_IDLE;
    end else begin
      case (st_reg.state)
        NSOC_IDLE: begin
          st_next.tcnt = '0;
          if (above) begin
            st_next.state = (trip_delay_in == '0) ? NSOC_TRIPPED : NSOC_PICKED;
          end
        end
        NSOC_PICKED: begin
          st_next.dcnt = '0;
          if (below) begin
            st_next.state = (drop_delay_in == '0) ? NSOC_IDLE : NSOC_DROPPING;
          end else if (tick_in) begin
            st_next.tcnt = st_reg.tcnt + 19'h1;
            if (st_reg.tcnt + 19'h1 >= trip_delay_in) begin
              st_next.state = NSOC_TRIPPED;
            end
          end
        end
        NSOC_DROPPING: begin
          // Trip timer is frozen while the dropout delay runs
          if (!below) begin
            st_next.state = NSOC_PICKED;
          end else if (drop_delay_in == '0) begin
            // Delay cleared while dropping: no need to wait for the next tick
            st_next.state = NSOC_IDLE;
          end else if (tick_in) begin
            st_next.dcnt = st_reg.dcnt + 16'h1;
            if (st_reg.dcnt + 16'h1 >= drop_delay_in) begin
              st_next.state = NSOC_IDLE;
            end
          end
        end
        NSOC_TRIPPED: begin
          if (below) begin
            st_next.state = NSOC_IDLE;
          end
        end
        default: st_next.state = NSOC_IDLE;
      endcase
    end
    st_next.pick = (st_next.state != NSOC_IDLE);
    st_next.trip = (st_next.state == NSOC_TRIPPED);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '{state: NSOC_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pickup_out = st_reg.pick;
  assign trip_out = st_reg.trip;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  trip_has_pick_a: assert property (trip_out |-> pickup_out)
    else $error("trip without pickup");
  off_quiet_a: assert property (!enable_in |=> !pickup_out && !trip_out)
    else $error("disabled stage active");
  no_early_pick_a: assert property (live && !pickup_out && !above |=> !pickup_out)
    else $error("pickup below pickup level");
  hyst_hold_a: assert property (live && pickup_out && !below |=> pickup_out)
    else $error("pickup lost above reset level");
  zero_trip_a: assert property (live && !pickup_out && above && trip_delay_in == '0
    |=> trip_out)
    else $error("zero delay did not trip");
  instant_drop_a: assert property (live && pickup_out && below && drop_delay_in == '0
    |=> !pickup_out)
    else $error("instant reset missed");
  drop_hold_a: assert property (live && st_reg.state == NSOC_PICKED && below
    && drop_delay_in != '0 |=> pickup_out)
    else $error("dropout delay not held");
  trip_reset_a: assert property (live && trip_out && below |=> !pickup_out)
    else $error("tripped stage did not reset");
  trip_seen_c: cover property (live && $rose(trip_out));
  drop_back_c: cover property (st_reg.state == NSOC_DROPPING ##1 st_reg.state == NSOC_PICKED);
endmodule : nsoc_stage

// [testbench/nsoc_chan_model.sv]
`timescale 1ns/1ps
module nsoc_chan_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] mag_in,
  output logic signed [15:0] c_out [6],
  output logic valid_out
);
  logic [1:0] cnt;
  int h;
  int m;
  // Pure negative sequence set: B leads A by 120, C lags by 120
  assign m = int'(mag_in);
  assign h = $rtoi(m * 0.8660254 + 0.5);
  // Sample every fourth cycle; between samples the lanes toggle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 2'h0;
      valid_out <= 1'b0;
      c_out <= '{default: 16'h0};
    end else begin
      cnt <= cnt + 2'h1;
      valid_out <= (cnt == 2'h3);
      if (cnt == 2'h3) begin
        c_out <= '{16'(m), 16'h0, 16'(-m / 2), 16'(h), 16'(-m / 2), 16'(-h)};
      end else begin
        foreach (c_out[i]) c_out[i] <= ~c_out[i];
      end
    end
  end
endmodule : nsoc_chan_model

// [testbench/nsoc_top_tb.sv]
`timescale 1ns/1ps
module nsoc_top_tb;
  logic clk_in, rst_n_in, psel, pen, pwr, pready, perr, valid, gblk, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] c [6];
  logic [15:0] mag;
  logic [3:0] sblk, pick, trip, blkd;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h60, 8'h64, 8'h68, 8'h6C,
                                     8'h70, 8'h74, 8'h78, 8'h7C};
  localparam logic [31:0] RV [11] = '{32'h0, 32'h0, 32'h3E8, 32'h7D0, 32'h190, 32'h0, 32'h0,
                                      32'h16A8, 32'h4B0, 32'h3E8, 32'h3E8};

  // Short tick so millisecond timers fit in a brief run
  nsoc_top #(.TICK_CYCLES(5)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .ia_re_in(c[0]),
    .ia_im_in(c[1]), .ib_re_in(c[2]), .ib_im_in(c[3]), .ic_re_in(c[4]), .ic_im_in(c[5]),
    .sample_valid_in(valid), .stage_block_input_in(sblk), .general_block_in(gblk),
    .pickup_out(pick), .trip_out(trip), .stage_blocked_flag_out(blkd));
  nsoc_chan_model chan (.clk_in(clk_in), .rst_n_in(rst_n_in), .mag_in(mag), .c_out(c),
    .valid_out(valid));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Hang guard: the tests need well under 2000 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic outs(input logic [3:0] p, input logic [3:0] t);
    check("pickup", pick, p);
    check("trip", trip, t);
  endtask : outs

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    {rst_n_in, psel, pen, pwr, gblk, paddr, pwdata, sblk, mag} = '0;
    wt(3);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, RA[i], 32'h0);
      check("reset value", rd, RV[i]);
    end
    apb(1'b0, 8'h2C, 32'h0);
    check("unmapped error", 32'(e), 32'h1);
    apb(1'b1, 8'h60, 32'h0);
    apb(1'b0, 8'h60, 32'h0);
    check("threshold clamp", rd, 32'h5);
    $display("test registers done");
    // Rated 100 and 5.0 pu put the level at 500, reset level 480
    apb(1'b1, 8'h08, 32'h64);
    apb(1'b1, 8'h20, 32'h1388);
    apb(1'b1, 8'h40, 32'h1388);
    apb(1'b1, 8'h44, 32'hA);
    apb(1'b1, 8'h48, 32'h14);
    apb(1'b1, 8'h00, 32'h3);
    mag <= 16'h3E8;
    wt(12);
    outs(4'h3, 4'h1);
    apb(1'b0, 8'h10, 32'h0);
    check("magnitude", 32'(rd > 32'h3C6CC && rd < 32'h3DA54), 32'h1);
    wt(24);
    outs(4'h3, 4'h1);
    wt(30);
    outs(4'h3, 4'h3);
    mag <= 16'h1EA;
    wt(12);
    outs(4'h3, 4'h3);
    mag <= 16'h190;
    wt(12);
    outs(4'h0, 4'h0);
    $display("test definite time done");
    apb(1'b1, 8'h44, 32'h3E8);
    mag <= 16'h3E8;
    wt(12);
    mag <= 16'h190;
    wt(12);
    outs(4'h2, 4'h0);
    wt(50);
    outs(4'h2, 4'h0);
    wt(60);
    outs(4'h0, 4'h0);
    $display("test dropout done");
    mag <= 16'h3E8;
    gblk <= 1'b1;
    wt(12);
    check("blocked", blkd, 4'hF);
    outs(4'h0, 4'h0);
    gblk <= 1'b0;
    sblk <= 4'h1;
    wt(12);
    check("blocked", blkd, 4'h1);
    outs(4'h2, 4'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check("status", rd, 32'h102);
    $display("test blocking done");
    // Inverse stage 3 picks up above 520, resets below 500, trips at min time
    mag <= 16'h1FE;
    apb(1'b1, 8'h60, 32'h1388);
    apb(1'b1, 8'h74, 32'h4);
    apb(1'b1, 8'h00, 32'h104);
    wt(12);
    outs(4'h0, 4'h0);
    mag <= 16'h21C;
    wt(12);
    outs(4'h4, 4'h0);
    wt(30);
    outs(4'h4, 4'h4);
    mag <= 16'h1F9;
    wt(12);
    outs(4'h4, 4'h4);
    mag <= 16'h1EA;
    wt(12);
    outs(4'h0, 4'h0);
    mag <= 16'h21C;
    wt(12);
    outs(4'h4, 4'h0);
    // Reset in mid-run clears stage state and settings
    rst_n_in <= 1'b0;
    wt(2);
    outs(4'h0, 4'h0);
    rst_n_in <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check("enable after reset", rd, 32'h0);
    $display("test inverse done");
    tally_and_finish();
  end
endmodule : nsoc_top_tb
